/* smbus_address_status_logic.v */
`timescale 1ns/1ps
`default_nettype none
`include "smbus_consts.vh"

module smbus_address_status_logic (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire master_mode,
  input wire ev_start,
  input wire ev_rstart,
  input wire ev_addr,
  input wire ev_data,
  input wire ev_rw,
  input wire ev_ack,
  input wire ev_arb_lost,
  input wire ev_timeout,
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte,
  output reg event_flag,
  output reg assert_ack_flag
);

  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_ADDR = 2'b01;
  localparam [1:0] S_SRX = 2'b10;
  localparam [1:0] S_STX = 2'b11;

  // Byte address of a register from its index.
  function [11:0] reg_addr;
    input [7:0] idx;
    begin
      reg_addr = {2'b00, idx, 2'b00};
    end
  endfunction

  reg [7:0] bus_phase_register;
  reg [7:0] own_address_register;
  reg smbus_enable;
  reg halt_condition_request;
  reg [1:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg ack_drive;
  reg tx_drive;
  reg gc_hit;
  reg gc_mode;
  reg ack_in;
  reg arb_flag;
  reg master_read;
  reg scl_d;
  reg sda_d;
  reg post;
  reg [7:0] pcode;

  wire [1:0] pins_s;
  wire scl_s;
  wire sda_s;

  // Both bus lines pass two flops before any logic looks at them.
  smbus_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d_in({scl_in, sda_in}),
    .q_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Clock edges and bus conditions seen on the synchronised lines.
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // Register decode; accesses that hit no register answer with pslverr.
  wire sel_ctrl = (paddr == reg_addr(`IDX_CTRL));
  wire sel_phase = (paddr == reg_addr(`IDX_PHASE));
  wire sel_own = (paddr == reg_addr(`IDX_OWNADR));
  wire apb_take = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire ctrl_wr = apb_done & pwrite & sel_ctrl;
  wire flag_clr = ctrl_wr & ~pwdata[`CTRL_EVT_BIT];

  // Slave-side qualifiers.
  wire addressed = (state == S_SRX) | (state == S_STX);
  wire halt_act = halt_condition_request & ~master_mode;
  wire byte_end = scl_fall & (bit_cnt == 4'd9) & (state != S_IDLE);
  // A START or STOP in the first clock of a byte is legal; later in the byte it is an error unless we are master.
  wire bus_err = (start_c | stop_c) & (state != S_IDLE) & (bit_cnt > 4'd1) & ~master_mode;

  // Own-address and general-call hits; matching is off while we are master.
  wire slave_ok = smbus_enable & ~master_mode & assert_ack_flag;
  wire own_match = slave_ok & (shreg[7:1] == own_address_register[7:1]);
  wire gc_match = slave_ok & own_address_register[`ADR_GC_BIT] & (shreg == 8'h00);

  // APB slave: one wait state, then pready for one cycle with the data.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      own_address_register <= `OWNADR_RESET;
      smbus_enable <= 1'b0;
      assert_ack_flag <= 1'b0;
      halt_condition_request <= 1'b0;
    end else begin
      pready <= apb_take;
      if (apb_take) begin
        pslverr <= ~(sel_ctrl | sel_phase | sel_own);
        if (sel_phase) begin
          prdata <= {24'h00_0000, bus_phase_register[7:3], 3'b000};
        end else if (sel_own) begin
          prdata <= {24'h00_0000, own_address_register};
        end else if (sel_ctrl) begin
          prdata <= {24'h00_0000, 1'b0, smbus_enable, 1'b0, halt_condition_request,
                     event_flag, assert_ack_flag, 2'b00};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
      // Writes to the status register are accepted and dropped.
      if (apb_done & pwrite & sel_own) begin
        own_address_register <= pwdata[7:0];
      end
      if (ctrl_wr) begin
        smbus_enable <= pwdata[`CTRL_EN_BIT];
        assert_ack_flag <= pwdata[`CTRL_AA_BIT];
      end
      // A slave-mode halt acts at once; a master-mode halt waits for a STOP.
      halt_condition_request <= (ctrl_wr & pwdata[`CTRL_HALT_BIT]) |
                                (halt_condition_request & master_mode & ~stop_c);
    end
  end

  // Picks the state code to publish this cycle, if any.
  always @* begin
    post = 1'b1;
    pcode = `ST_IDLE;
    if (ev_timeout) begin
      pcode = `ST_TIMEOUT;
    end else if (bus_err) begin
      pcode = `ST_BUS_ERR;
    end else if (master_mode & ev_start) begin
      pcode = `ST_START;
    end else if (master_mode & ev_rstart) begin
      pcode = `ST_RSTART;
    end else if (master_mode & ev_addr) begin
      if (ev_rw) begin
        pcode = ev_ack ? `ST_AR_ACK : `ST_AR_NACK;
      end else begin
        pcode = ev_ack ? `ST_AW_ACK : `ST_AW_NACK;
      end
    end else if (master_mode & ev_data) begin
      if (master_read) begin
        pcode = ev_ack ? `ST_MRX_ACK : `ST_MRX_NACK;
      end else begin
        pcode = ev_ack ? `ST_MTX_ACK : `ST_MTX_NACK;
      end
    end else if (ev_arb_lost & (state == S_IDLE)) begin
      pcode = `ST_ARB_LOST;
    end else if ((start_c | stop_c) & addressed) begin
      pcode = `ST_SLV_STOP;
    end else if (byte_end) begin
      case (state)
        S_ADDR: begin
          if (ack_drive & gc_hit) begin
            pcode = arb_flag ? `ST_ARB_GCALL : `ST_GCALL;
          end else if (ack_drive & shreg[0]) begin
            pcode = arb_flag ? `ST_ARB_OWN_R : `ST_OWN_R;
          end else if (ack_drive) begin
            pcode = arb_flag ? `ST_ARB_OWN_W : `ST_OWN_W;
          end else if (arb_flag) begin
            pcode = `ST_ARB_LOST;
          end else begin
            post = 1'b0;
          end
        end
        S_SRX: begin
          if (gc_mode) begin
            pcode = ack_drive ? `ST_GRX_ACK : `ST_GRX_NACK;
          end else begin
            pcode = ack_drive ? `ST_SRX_ACK : `ST_SRX_NACK;
          end
        end
        S_STX: begin
          if (!ack_in) begin
            pcode = `ST_STX_NACK;
          end else begin
            pcode = assert_ack_flag ? `ST_STX_ACK : `ST_STX_LAST;
          end
        end
        default: begin
          post = 1'b0;
        end
      endcase
    end else begin
      post = 1'b0;
    end
  end

  // Status code and event flag; a new event beats a software clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_phase_register <= `ST_IDLE;
      event_flag <= 1'b0;
    end else begin
      event_flag <= post | (event_flag & ~flag_clr);
      if (post) begin
        bus_phase_register <= pcode;
      end else if (~master_mode & (state == S_IDLE) &
                   (flag_clr | halt_act | (~event_flag & stop_c))) begin
        bus_phase_register <= `ST_IDLE;
      end
    end
  end

  // Slave sequencer: address shifting, ack decisions and byte framing.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= S_IDLE;
      bit_cnt <= 4'd0;
      shreg <= 8'h00;
      ack_drive <= 1'b0;
      gc_hit <= 1'b0;
      gc_mode <= 1'b0;
      ack_in <= 1'b0;
      arb_flag <= 1'b0;
      master_read <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (master_mode & ev_addr) begin
        master_read <= ev_rw;
      end
      if (~smbus_enable | stop_c | bus_err | halt_act) begin
        state <= S_IDLE;
        bit_cnt <= 4'd0;
        ack_drive <= 1'b0;
        arb_flag <= 1'b0;
      end else if (start_c) begin
        // While enabled and not halted, every START that is not a bus error, our own included, begins an address phase.
        state <= S_ADDR;
        bit_cnt <= 4'd0;
        ack_drive <= 1'b0;
        arb_flag <= 1'b0;
      end else if (state != S_IDLE) begin
        if (ev_arb_lost) begin
          arb_flag <= 1'b1;
        end
        if (scl_rise & (bit_cnt < 4'd8)) begin
          shreg <= {shreg[6:0], sda_s};
        end
        if (scl_rise & (bit_cnt == 4'd8)) begin
          ack_in <= ~sda_s;
        end
        if (scl_rise & (bit_cnt < 4'd9)) begin
          bit_cnt <= bit_cnt + 4'd1;
        end
        // After the eighth bit decide whether to pull SDA low for the ack.
        if (scl_fall & (bit_cnt == 4'd8)) begin
          case (state)
            S_ADDR: begin
              gc_hit <= gc_match;
              ack_drive <= own_match | gc_match;
            end
            S_SRX: begin
              rx_byte <= shreg;
              ack_drive <= assert_ack_flag;
            end
            default: begin
              ack_drive <= 1'b0;
            end
          endcase
        end
        // End of the ack clock: release SDA and choose the next phase.
        if (byte_end) begin
          bit_cnt <= 4'd0;
          ack_drive <= 1'b0;
          arb_flag <= 1'b0;
          case (state)
            S_ADDR: begin
              gc_mode <= gc_hit;
              if (!ack_drive) begin
                state <= S_IDLE;
              end else begin
                state <= shreg[0] ? S_STX : S_SRX;
              end
            end
            S_SRX: begin
              if (!ack_drive) begin
                state <= S_IDLE;
              end
            end
            default: begin
              if (!(ack_in & assert_ack_flag)) begin
                state <= S_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  // Open-drain pin drivers; data bits change only while SCL is low.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      tx_drive <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      if (~scl_s | (state == S_IDLE)) begin
        tx_drive <= (state == S_STX) & (bit_cnt < 4'd8) &
                    ~tx_byte[3'd7 - bit_cnt[2:0]];
      end
      sda_oe_n <= ~(ack_drive | tx_drive);
      scl_oe_n <= ~(event_flag & ~scl_s);
    end
  end

endmodule

`default_nettype wire

/* smbus_consts.vh */
// Function
// - Slave compares received 7-bit address with own-address bits 7..1, acks on match.
// - Own-address bit 0 set: accept all-zero general call; clear: ignore it.
// - While master, own-address register contents are disregarded.
// - Own-address bit 7 meets first address bit on the bus, then descending.
// - Status is 8 bits: upper five vary, lower three read zero.
// - Status resets to idle code 0xF8; idle never sets the event flag.
// - Master START sent reports 0x08; repeated START sent reports 0x10.
// - Address with write sent reports 0x18 on ack, 0x20 on nack.
// - Master transmitter data byte reports 0x28 on ack, 0x30 on nack.
// - Arbitration lost then addressed: 0x68 own write, 0x78 general call, 0xB0 own read.
// - Address with read sent reports 0x40 on ack, 0x48 on nack.
// - Master receiver data byte reports 0x50 if acked, 0x58 if not.
// - Own address with write: ack, report 0x60; enabled general call: ack, 0x70.
// - Addressed slave receiver data byte reports 0x80 acked, 0x88 not acked.
// - Data byte after general call reports 0x90 acked, 0x98 not acked.
// - Addressed slave seeing STOP or repeated START reports 0xA0.
// - Own address with read: ack, report 0xA8, software supplies byte to send.
// - Slave transmitter byte reports 0xB8 on master ack, 0xC0 on nack.
// - Ack flag cleared before final byte and master acks: report 0xC8.
// - Clock-high timer expiry reports timeout code 0xD0.
// - Illegal START or STOP reports bus error code 0x00; the code flags it only while not master.
// - Any non-idle state sets the event flag; only software clears it.
// - Event flag set while clock low holds the clock low until cleared.
`ifndef SMBUS_CONSTS_VH
`define SMBUS_CONSTS_VH
`define IDX_CTRL 8'hC0
`define IDX_PHASE 8'hC1
`define IDX_OWNADR 8'hC3
`define OWNADR_RESET 8'h00
`define CTRL_EN_BIT 6
`define CTRL_HALT_BIT 4
`define CTRL_EVT_BIT 3
`define CTRL_AA_BIT 2
`define ADR_GC_BIT 0
`define ST_BUS_ERR 8'h00
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_AW_ACK 8'h18
`define ST_AW_NACK 8'h20
`define ST_MTX_ACK 8'h28
`define ST_MTX_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_AR_ACK 8'h40
`define ST_AR_NACK 8'h48
`define ST_MRX_ACK 8'h50
`define ST_MRX_NACK 8'h58
`define ST_OWN_W 8'h60
`define ST_ARB_OWN_W 8'h68
`define ST_GCALL 8'h70
`define ST_ARB_GCALL 8'h78
`define ST_SRX_ACK 8'h80
`define ST_SRX_NACK 8'h88
`define ST_GRX_ACK 8'h90
`define ST_GRX_NACK 8'h98
`define ST_SLV_STOP 8'hA0
`define ST_OWN_R 8'hA8
`define ST_ARB_OWN_R 8'hB0
`define ST_STX_ACK 8'hB8
`define ST_STX_NACK 8'hC0
`define ST_STX_LAST 8'hC8
`define ST_TIMEOUT 8'hD0
`define ST_IDLE 8'hF8
`endif

/* smbus_far_master.sv */
`timescale 1ns/1ps
`default_nettype none
module smbus_far_master (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  // Both lines rest released; the pull-ups hold them high between frames.
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // One clock pulse; waits while a slave stretches the low phase.
  task automatic pulse(output logic seen);
    #32 scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #16 seen = sda_line;
    #16 scl_drv = 1'b0;
  endtask
  // Data falls while the clock is high.
  task automatic start_cond;
    sda_drv = 1'b0;
    #32 scl_drv = 1'b0;
  endtask
  // Sends eight bits first-bit-first, then samples the acknowledge.
  task automatic send(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      pulse(s);
    end
    sda_drv = 1'b1;
    pulse(s);
    acked = !s;
  endtask
  // Data falls in the middle of a byte while the clock is high: an illegal START.
  task automatic stray_start;
    #32 scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #16 sda_drv = 1'b0;
    #16 scl_drv = 1'b0;
  endtask
  // Data rises while the clock is high.
  task automatic stop_cond;
    sda_drv = 1'b0;
    #32 scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #32 sda_drv = 1'b1;
    #32;
  endtask
endmodule
`default_nettype wire

/* smbus_pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

module smbus_pin_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d_in,
  output reg [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta;

  // Two flops per line; lines idle high, so reset to ones.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b1}};
      q_out <= {WIDTH{1'b1}};
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule

`default_nettype wire

/* smbus_status_props.sv */
`timescale 1ns/1ps
`default_nettype none
module smbus_status_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scl_in,
  input wire scl_oe_n,
  input wire master_mode,
  input wire ev_start,
  input wire ev_timeout,
  input wire event_flag
);
  // Decodes the mapped registers and a software clear of the flag.
  wire mapped = paddr == 12'h300 || paddr == 12'h304 || paddr == 12'h30c;
  wire clr = psel && penable && pready && pwrite && paddr == 12'h300 && !pwdata[3];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The bus answers after exactly one wait state, for one cycle.
  a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match decode");
  a_status_low: assert property (pready && !pwrite && paddr == 12'h304 |-> prdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_reset_idle: assert property ($rose(presetn) |-> !event_flag)
    else $error("flag set out of reset");
  a_start_flag: assert property (ev_start && master_mode |=> event_flag)
    else $error("start did not set flag");
  a_timeout_flag: assert property (ev_timeout |=> event_flag)
    else $error("timeout did not set flag");
  a_flag_holds: assert property (event_flag && !clr |=> event_flag)
    else $error("flag dropped without software clear");
  a_clock_held: assert property ((event_flag && !scl_in) [*4] |-> !scl_oe_n)
    else $error("clock not held while flag set");
  a_clock_free: assert property ((!event_flag) [*4] |-> scl_oe_n)
    else $error("clock held with flag clear");
  c_start: cover property (ev_start && master_mode);
  c_stretch: cover property (!scl_oe_n);
  c_unmapped: cover property (pready && pslverr);
endmodule
bind smbus_address_status_logic smbus_status_props props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .scl_oe_n, .master_mode,
  .ev_start, .ev_timeout, .event_flag);
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic master_mode = 1'b0;
  logic [5:0] ev = 6'h00;
  logic ev_rw = 1'b0;
  logic ev_ack = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, event_flag, assert_ack_flag;
  wire scl_drv, sda_drv;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e, a;
  logic [15:0] rows [13] = '{16'h8008, 16'h2118, 16'h1128, 16'h1030, 16'h4010, 16'h2020,
    16'h4010, 16'h2340, 16'h1150, 16'h1058, 16'h2248, 16'h0838, 16'h04d0};
  // Wired-AND lines with pull-ups.
  wire scl = scl_drv & (scl_oe_n | scl_out);
  wire sda = sda_drv & (sda_oe_n | sda_out);
  always #2 pclk = ~pclk;
  smbus_address_status_logic DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out,
    .sda_oe_n, .master_mode, .ev_start(ev[5]), .ev_rstart(ev[4]), .ev_addr(ev[3]),
    .ev_data(ev[2]), .ev_rw, .ev_ack, .ev_arb_lost(ev[1]), .ev_timeout(ev[0]),
    .tx_byte(8'h5a), .rx_byte(), .event_flag, .assert_ack_flag);
  smbus_far_master m (.scl_line(scl), .sda_line(sda), .scl_drv, .sda_drv);
  function automatic logic [31:0] b32(input logic x);
    return {31'h0000_0000, x};
  endfunction
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; result lands in q and e.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input logic [5:0] v, input logic rw, input logic ak);
    @(posedge pclk);
    ev <= v;
    ev_rw <= rw;
    ev_ack <= ak;
    @(posedge pclk);
    ev <= 6'h00;
  endtask
  // Far master addresses the device; software serves the event while the clock is held.
  task automatic slave(input logic [7:0] b, input logic want, input logic [7:0] code);
    m.start_cond();
    m.send(b, a);
    chk("ack", b32(want), b32(a));
    if (want) begin
      fork
        m.stop_cond();
        begin
          wait (event_flag === 1'b1);
          apb(1'b0, 12'h304, 32'h0000_0000);
          chk("status", {24'h00_0000, code}, q);
          chk("clock hold", 32'h0000_0000, b32(scl_oe_n));
          apb(1'b1, 12'h300, 32'h0000_0044);
        end
      join
      repeat (8) @(posedge pclk);
      apb(1'b0, 12'h304, 32'h0000_0000);
      chk("status", 32'h0000_00a0, q);
      apb(1'b1, 12'h300, 32'h0000_0044);
    end else begin
      m.stop_cond();
      chk("flag", 32'h0000_0000, b32(event_flag));
    end
  endtask
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  // Main sequence: reset, register checks, event table, then link cases.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h304, 32'h0000_0000);
    chk("status", 32'h0000_00f8, q);
    chk("flag", 32'h0000_0000, b32(event_flag));
    chk("sda_out", 32'h0000_0000, b32(sda_out));
    chk("scl_out", 32'h0000_0000, b32(scl_out));
    apb(1'b0, 12'h30c, 32'h0000_0000);
    chk("own address", 32'h0000_0000, q);
    apb(1'b1, 12'h304, 32'h0000_0000);
    apb(1'b0, 12'h304, 32'h0000_0000);
    chk("status", 32'h0000_00f8, q);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, b32(e));
    apb(1'b1, 12'h300, 32'h0000_0044);
    apb(1'b1, 12'h30c, 32'h0000_00a8);
    apb(1'b0, 12'h30c, 32'h0000_0000);
    chk("own address", 32'h0000_00a8, q);
    chk("ack flag", 32'h0000_0001, b32(assert_ack_flag));
    master_mode <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      fire(rows[i][15:10], rows[i][9], rows[i][8]);
      apb(1'b0, 12'h304, 32'h0000_0000);
      chk("status", {24'h00_0000, rows[i][7:0]}, q);
      chk("flag", 32'h0000_0001, b32(event_flag));
    end
    master_mode <= 1'b0;
    apb(1'b1, 12'h300, 32'h0000_0044);
    apb(1'b0, 12'h304, 32'h0000_0000);
    chk("status", 32'h0000_00f8, q);
    chk("flag", 32'h0000_0000, b32(event_flag));
    slave(8'ha8, 1'b1, 8'h60);
    slave(8'h15, 1'b0, 8'h00);
    slave(8'h00, 1'b0, 8'h00);
    apb(1'b1, 12'h30c, 32'h0000_00a9);
    slave(8'h00, 1'b1, 8'h70);
    // A START between data bits is reported as a bus error.
    m.start_cond();
    m.send(8'ha8, a);
    wait (event_flag === 1'b1);
    apb(1'b1, 12'h300, 32'h0000_0044);
    m.pulse(a);
    m.pulse(a);
    m.stray_start();
    wait (event_flag === 1'b1);
    apb(1'b0, 12'h304, 32'h0000_0000);
    chk("status", 32'h0000_0000, q);
    apb(1'b1, 12'h300, 32'h0000_0044);
    m.stop_cond();
    master_mode <= 1'b1;
    slave(8'ha8, 1'b0, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
